// [verilog/mfcb_pkg.sv]
// mfcb_pkg: register map, field positions and shared types for the flow-control and buffer-count block.
// assumes a plain strobe register port and a single 50 MHz clock domain.
package mfcb_pkg;
    // -------------------------------------------------------------------------
    // register map (word offsets chosen for the plain port)
    // -------------------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL_ONE  = 4'h0;
    localparam logic [3:0] ADDR_STATUS       = 4'h1;
    localparam logic [3:0] ADDR_PAUSE_TIMER  = 4'h2;
    localparam logic [3:0] ADDR_WATERMARKS   = 4'h3;
    localparam logic [3:0] ADDR_RX_DESC_ST   = 4'h4;
    localparam logic [3:0] ADDR_IRQ_ENABLES  = 4'h5;
    // -------------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------------
    localparam int CTL_ON_BIT       = 15;
    localparam int CTL_RXON_BIT     = 8;
    localparam int CTL_AUTO_BIT     = 7;
    localparam int CTL_MANUAL_BIT   = 4;
    localparam int CTL_DEC_BIT      = 0;
    localparam int ST_COUNT_LSB     = 16;
    localparam int ST_MODULE_BIT    = 7;
    localparam int ST_TX_BIT        = 6;
    localparam int ST_RX_BIT        = 5;
    localparam int WM_EMPTY_LSB     = 0;
    localparam int WM_FULL_LSB      = 16;
    localparam int IEN_PENDING_BIT  = 6;
    localparam int IRQ_PEND_BIT     = 6;
    // -------------------------------------------------------------------------
    // reset values and timing
    // -------------------------------------------------------------------------
    localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
    localparam logic [7:0]  COUNT_MAX    = 8'hFF;
    localparam logic [7:0]  COUNT_ZERO   = 8'h00;
    localparam logic [15:0] PAUSE_ZERO   = 16'h0000;
    localparam int          QUANTA_HALF  = 64;
    localparam real         TXCLK_10M_MHZ  = 2.5;
    localparam real         TXCLK_100M_MHZ = 25.0;
    localparam int          MODULE_DRAIN_CYCLES = 4;

    typedef struct packed {
        logic        valid;
        logic [15:0] quanta;
    } mfcb_pause_s;

    typedef enum logic [2:0] {
        PS_IDLE  = 3'b001,
        PS_WAIT  = 3'b010,
        PS_SEND  = 3'b100
    } mfcb_pause_e;
endpackage

// [verilog/mfcb_top.sv]
// mfcb_top: pause-frame generation, received-buffer counting and busy status of an ethernet controller.
// assumes tx_clk_tick is a one-cycle pulse per tx clock edge from the tx domain, already synchronous here;
// rx and tx activity inputs come from mac logic on the same clock.
//
// Notes on behaviour
// - auto pause on and count reaches full watermark turns flow control on.
// - auto pause on and count falls to empty watermark turns flow control off.
// - manual pause sends pause frame, resent every 128*value/2 tx clocks.
// - clearing manual pause sends one pause frame with zero timer value.
// - tx clock is 2.5 MHz at 10 Mbps, 25 MHz at 100 Mbps.
// - decrement control reads zero; writing one decrements count, zero does nothing.
// - simultaneous decrement and increment leave the count unchanged.
// - 8-bit count in status bits 23..16, raised by descriptors per packet.
// - count saturates at maximum and at zero.
// - auto flow control on and count at maximum stalls receive logic.
// - auto flow control off, receive keeps going, count stays saturated.
// - count non-zero holds packet pending flag; irq only when enabled.
// - any write to rx descriptor start address clears the count.
// - turning module off does not clear the count.
// - module active bit 7 set while on or finishing after off.
// - transmit active bit 6 shows transmitting, zero when module off.
// - receive active bit 5 shows receiving, zero when module off.
// - busy transitions need not produce complete events.
// - status bits 31..24, 15..8, 4..0 read zero.
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module mfcb_top #(
    parameter int DESC_W = 4
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // register port
    input  wire logic [3:0]             reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [31:0]                 reg_rdata,
    // tx clock tick and mac activity
    input  wire logic                   tx_clk_tick,
    input  wire logic                   tx_active_in,
    input  wire logic                   rx_active_in,
    input  wire logic                   module_drain_in,
    // receive packet done and descriptor count
    input  wire logic                   rx_pkt_done,
    input  wire logic [DESC_W-1:0]      rx_pkt_desc,
    // pause frame request to mac transmitter
    output mfcb_pkg::mfcb_pause_s       pause_req,
    input  wire logic                   pause_ack,
    // flow control state, receive stall and module and receive path enables
    output logic                        flow_ctrl_on,
    output logic                        rx_stall,
    output logic                        module_on,
    output logic                        rx_path_on,
    // packet pending
    output logic                        packet_pending_flag,
    output logic                        packet_pending_irq
);
    // -------------------------------------------------------------------------
    // register decode
    // -------------------------------------------------------------------------
    logic [31:0] ctl_q, ctl_d;
    logic [15:0] ptv_q;
    logic [31:0] wm_q;
    logic [31:0] ien_q;
    logic [7:0]  cnt_q, cnt_d;
    logic        fc_q, fc_d;
    logic [31:0] rdata_q;
    logic        wr_ctl, wr_ptv, wr_wm, wr_rxst, wr_ien;
    logic        dec_req;
    assign wr_ctl  = reg_wr && (reg_addr == mfcb_pkg::ADDR_CONTROL_ONE);
    assign wr_ptv  = reg_wr && (reg_addr == mfcb_pkg::ADDR_PAUSE_TIMER);
    assign wr_wm   = reg_wr && (reg_addr == mfcb_pkg::ADDR_WATERMARKS);
    assign wr_rxst = reg_wr && (reg_addr == mfcb_pkg::ADDR_RX_DESC_ST);
    assign wr_ien  = reg_wr && (reg_addr == mfcb_pkg::ADDR_IRQ_ENABLES);
    assign dec_req = wr_ctl && reg_wdata[mfcb_pkg::CTL_DEC_BIT];

    logic on_w, auto_w, man_w;
    logic [7:0] full_wm, empty_wm;
    assign on_w     = ctl_q[mfcb_pkg::CTL_ON_BIT];
    assign auto_w   = ctl_q[mfcb_pkg::CTL_AUTO_BIT];
    assign man_w    = ctl_q[mfcb_pkg::CTL_MANUAL_BIT];
    assign full_wm  = wm_q[mfcb_pkg::WM_FULL_LSB +: 8];
    assign empty_wm = wm_q[mfcb_pkg::WM_EMPTY_LSB +: 8];

    // decrement bit is never stored so it always reads back zero
    always_comb begin
        ctl_d = ctl_q;
        if (wr_ctl) begin
            ctl_d = reg_wdata;
            ctl_d[mfcb_pkg::CTL_DEC_BIT] = 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // received buffer count
    // -------------------------------------------------------------------------
    function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [DESC_W-1:0] b);
        logic [8:0] s;
        s = {1'b0, a} + 9'(b);
        sat_add = s[8] ? mfcb_pkg::COUNT_MAX : s[7:0];
    endfunction

    logic inc_req;
    assign inc_req = rx_pkt_done && (rx_pkt_desc != '0);

    // clearing by start-address write wins; the off state never touches the count
    always_comb begin
        cnt_d = cnt_q;
        if (wr_rxst) begin
            cnt_d = mfcb_pkg::COUNT_ZERO;
        end else if (inc_req && dec_req) begin
            // the two strobes cancel whole, whatever the descriptor count of the packet
            cnt_d = cnt_q;
        end else if (inc_req) begin
            cnt_d = sat_add(cnt_q, rx_pkt_desc);
        end else if (dec_req && cnt_q != mfcb_pkg::COUNT_ZERO) begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    // -------------------------------------------------------------------------
    // automatic flow control
    // -------------------------------------------------------------------------
    always_comb begin
        fc_d = fc_q;
        if (!auto_w) begin
            fc_d = 1'b0;
        end else if (cnt_q >= full_wm) begin
            fc_d = 1'b1;
        end else if (cnt_q <= empty_wm) begin
            fc_d = 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // manual pause frames: interval counted in tx clock ticks
    // -------------------------------------------------------------------------
    // interval of 128*value/2 ticks; a zero value gives one frame and no repeat
    mfcb_pkg::mfcb_pause_e ps_q, ps_d;
    logic [22:0] tick_cnt_q, tick_cnt_d;
    logic        man_prev_q;
    logic        zero_pend_q, zero_pend_d;
    mfcb_pkg::mfcb_pause_s req_q, req_d;
    logic [22:0] interval;
    assign interval = 23'(ptv_q) * 23'(mfcb_pkg::QUANTA_HALF);

    always_comb begin
        ps_d        = ps_q;
        tick_cnt_d  = tick_cnt_q;
        req_d       = req_q;
        zero_pend_d = zero_pend_q;
        if (man_prev_q && !man_w) begin
            zero_pend_d = 1'b1;
        end
        if (req_q.valid && pause_ack) begin
            req_d.valid = 1'b0;
        end
        case (ps_q)
            mfcb_pkg::PS_IDLE: begin
                if (man_w) begin
                    ps_d = mfcb_pkg::PS_SEND;
                end else if (zero_pend_d && !req_q.valid) begin
                    req_d       = '{valid: 1'b1, quanta: mfcb_pkg::PAUSE_ZERO};
                    zero_pend_d = 1'b0;
                end
            end
            mfcb_pkg::PS_SEND: begin
                if (!man_w) begin
                    ps_d = mfcb_pkg::PS_IDLE;
                // a new frame waits one cycle past the ack so valid always drops between frames
                end else if (!req_q.valid) begin
                    req_d      = '{valid: 1'b1, quanta: ptv_q};
                    tick_cnt_d = '0;
                    ps_d       = mfcb_pkg::PS_WAIT;
                end
            end
            mfcb_pkg::PS_WAIT: begin
                if (!man_w) begin
                    ps_d = mfcb_pkg::PS_IDLE;
                end else if (tx_clk_tick) begin
                    tick_cnt_d = tick_cnt_q + 23'h1;
                    if (tick_cnt_d >= interval && interval != '0) begin
                        ps_d = mfcb_pkg::PS_SEND;
                    end
                end
            end
            default: ps_d = mfcb_pkg::PS_IDLE;
        endcase
    end

    // -------------------------------------------------------------------------
    // module busy and activity status
    // -------------------------------------------------------------------------
    logic mod_busy_q, tx_busy_q, rx_busy_q, stall_q, pend_q, irq_q;
    logic [2:0] drain_q;
    logic [31:0] status_w;
    assign status_w = {8'h00, cnt_q, 8'h00, mod_busy_q, tx_busy_q, rx_busy_q, 5'h00};

    logic [31:0] rd_mux;
    assign rd_mux = (reg_addr == mfcb_pkg::ADDR_CONTROL_ONE) ? ctl_q :
                    (reg_addr == mfcb_pkg::ADDR_STATUS)      ? status_w :
                    (reg_addr == mfcb_pkg::ADDR_PAUSE_TIMER) ? {16'h0000, ptv_q} :
                    (reg_addr == mfcb_pkg::ADDR_WATERMARKS)  ? wm_q :
                    (reg_addr == mfcb_pkg::ADDR_IRQ_ENABLES) ? ien_q :
                    mfcb_pkg::RESET_WORD;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q       <= mfcb_pkg::RESET_WORD;
            ptv_q       <= mfcb_pkg::PAUSE_ZERO;
            wm_q        <= mfcb_pkg::RESET_WORD;
            ien_q       <= mfcb_pkg::RESET_WORD;
            cnt_q       <= mfcb_pkg::COUNT_ZERO;
            fc_q        <= 1'b0;
            rdata_q     <= mfcb_pkg::RESET_WORD;
            ps_q        <= mfcb_pkg::PS_IDLE;
            tick_cnt_q  <= '0;
            man_prev_q  <= 1'b0;
            zero_pend_q <= 1'b0;
            req_q       <= '0;
        end else begin
            ctl_q       <= ctl_d;
            if (wr_ptv) ptv_q <= reg_wdata[15:0];
            if (wr_wm)  wm_q  <= reg_wdata & 32'h00FF_00FF;
            if (wr_ien) ien_q <= reg_wdata;
            cnt_q       <= cnt_d;
            fc_q        <= fc_d;
            rdata_q     <= reg_rd ? rd_mux : mfcb_pkg::RESET_WORD;
            ps_q        <= ps_d;
            tick_cnt_q  <= tick_cnt_d;
            man_prev_q  <= man_w;
            zero_pend_q <= zero_pend_d;
            req_q       <= req_d;
        end
    end

    // busy flags: module stays busy while draining after off, tx/rx forced low when off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mod_busy_q <= 1'b0;
            tx_busy_q  <= 1'b0;
            rx_busy_q  <= 1'b0;
            drain_q    <= '0;
            stall_q    <= 1'b0;
            pend_q     <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            drain_q    <= on_w ? 3'(mfcb_pkg::MODULE_DRAIN_CYCLES) :
                          (drain_q != '0 && !module_drain_in) ? drain_q - 3'h1 : drain_q;
            mod_busy_q <= on_w || module_drain_in || (drain_q != '0);
            tx_busy_q  <= on_w && tx_active_in;
            rx_busy_q  <= on_w && rx_active_in;
            stall_q    <= auto_w && (cnt_d == mfcb_pkg::COUNT_MAX);
            pend_q     <= (cnt_d != mfcb_pkg::COUNT_ZERO);
            irq_q      <= (cnt_d != mfcb_pkg::COUNT_ZERO) && ien_q[mfcb_pkg::IEN_PENDING_BIT];
        end
    end

    // -------------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------------
    assign reg_rdata           = rdata_q;
    assign pause_req           = req_q;
    assign flow_ctrl_on        = fc_q;
    assign rx_stall            = stall_q;
    assign module_on           = ctl_q[mfcb_pkg::CTL_ON_BIT];
    assign rx_path_on          = ctl_q[mfcb_pkg::CTL_RXON_BIT];
    assign packet_pending_flag = pend_q;
    assign packet_pending_irq  = irq_q;
endmodule

// [sim/mfcb_top_assertions.sv]
// mfcb_top_assertions: port checks of mfcb_top, bound after the module.
// assumes the single clk domain and async active-low rst_n of the top.
`timescale 1ns/1ns
module mfcb_checker #(
    parameter int DESC_W = 4
) (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rst_n,
    // register port
    input wire logic [3:0]            reg_addr,
    input wire logic [31:0]           reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [31:0]           reg_rdata,
    // mac side
    input wire logic                  tx_clk_tick,
    input wire logic                  tx_active_in,
    input wire logic                  rx_active_in,
    input wire logic                  module_drain_in,
    input wire logic                  rx_pkt_done,
    input wire logic [DESC_W-1:0]     rx_pkt_desc,
    input wire mfcb_pkg::mfcb_pause_s pause_req,
    input wire logic                  pause_ack,
    // state outputs
    input wire logic                  flow_ctrl_on,
    input wire logic                  rx_stall,
    input wire logic                  module_on,
    input wire logic                  rx_path_on,
    input wire logic                  packet_pending_flag,
    input wire logic                  packet_pending_irq
);
    // -------------------------------------------------------------------------
    // decode and properties
    // -------------------------------------------------------------------------
    wire logic st_rd  = reg_rd && reg_addr == mfcb_pkg::ADDR_STATUS;
    wire logic ctl_rd = reg_rd && reg_addr == mfcb_pkg::ADDR_CONTROL_ONE;
    wire logic ctl_wr = reg_wr && reg_addr == mfcb_pkg::ADDR_CONTROL_ONE;
    wire logic st_wr  = reg_wr && reg_addr == mfcb_pkg::ADDR_RX_DESC_ST;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_pause_hold; pause_req.valid && !pause_ack |=> pause_req.valid && $stable(pause_req.quanta); endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("pause request left before ack");
    property p_pause_drop; pause_req.valid && pause_ack |=> !pause_req.valid; endproperty
    a_pause_drop: assert property (p_pause_drop) else $error("pause request held after ack");
    property p_dec_zero; ctl_rd |=> reg_rdata[mfcb_pkg::CTL_DEC_BIT] == 1'b0; endproperty
    a_dec_zero: assert property (p_dec_zero) else $error("decrement bit read as one");
    property p_unused; st_rd |=> reg_rdata[31:24] == 8'h00 && reg_rdata[15:8] == 8'h00 && reg_rdata[4:0] == 5'h00;
    endproperty
    a_unused: assert property (p_unused) else $error("unused status bits not zero");
    property p_off_idle; st_rd && !module_on && !$past(module_on) && !$past(module_on, 2) |=> reg_rdata[6:5] == 2'h0;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("busy bits set while off");
    property p_on_busy; st_rd && module_on && $past(module_on) && $past(module_on, 2) |=> reg_rdata[7]; endproperty
    a_on_busy: assert property (p_on_busy) else $error("module active bit clear while on");
    property p_irq_flag; packet_pending_irq |-> packet_pending_flag; endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("irq without pending flag");
    property p_on_write; ctl_wr |=> module_on == $past(reg_wdata[mfcb_pkg::CTL_ON_BIT]); endproperty
    a_on_write: assert property (p_on_write) else $error("module on does not follow write");
    property p_clear; st_wr |=> !packet_pending_flag; endproperty
    a_clear: assert property (p_clear) else $error("count not cleared by start write");
endmodule
bind mfcb_top mfcb_checker #(.DESC_W(DESC_W)) mfcb_checker_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_clk_tick(tx_clk_tick),
    .tx_active_in(tx_active_in), .rx_active_in(rx_active_in), .module_drain_in(module_drain_in),
    .rx_pkt_done(rx_pkt_done), .rx_pkt_desc(rx_pkt_desc), .pause_req(pause_req), .pause_ack(pause_ack),
    .flow_ctrl_on(flow_ctrl_on), .rx_stall(rx_stall), .module_on(module_on), .rx_path_on(rx_path_on),
    .packet_pending_flag(packet_pending_flag), .packet_pending_irq(packet_pending_irq));

// [sim/mfcb_mac_model.sv]
// mfcb_mac_model: mac transmitter that takes pause frames and makes the tx clock tick.
// assumes pause_req holds until acked; the bench sets the ack delay.
`timescale 1ns/1ns
module mfcb_mac_model #(
    parameter int TICK_DIV = 2
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // pause link
    input  wire mfcb_pkg::mfcb_pause_s pause_req,
    input  wire logic [3:0]            ack_wait,
    output logic                       pause_ack,
    output logic                       tx_clk_tick,
    // frames seen
    output int                         frames,
    output logic [15:0]                last_quanta
);
    int         div_q;
    logic [3:0] wait_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q       <= 0;
            tx_clk_tick <= 1'b0;
            pause_ack   <= 1'b0;
            wait_q      <= 4'h0;
            frames      <= 0;
            last_quanta <= 16'h0000;
        end else begin
            // divide by 2 gives 25 MHz for 100 Mbps; 20 would give 2.5 MHz
            div_q       <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
            tx_clk_tick <= (div_q == TICK_DIV - 1);
            pause_ack   <= 1'b0;
            if (pause_req.valid && !pause_ack) begin
                wait_q <= wait_q + 4'h1;
                if (wait_q >= ack_wait) begin
                    pause_ack   <= 1'b1;
                    wait_q      <= 4'h0;
                    frames      <= frames + 1;
                    last_quanta <= pause_req.quanta;
                end
            end
        end
    end
endmodule

// [sim/mfcb_top_test.sv]
// mfcb_top_test: self-checking bench of mfcb_top with the mac model on the pause link.
// assumes the register map and field positions of mfcb_pkg.
`timescale 1ns/1ns
module mfcb_top_test;
    typedef struct packed { logic [3:0] desc; logic dec; logic [7:0] cnt; } mfcb_row_s;
    mfcb_row_s rows [5] = '{'{4'h3, 1'b0, 8'h03}, '{4'h1, 1'b1, 8'h03}, '{4'h0, 1'b1, 8'h02},
                            '{4'h4, 1'b1, 8'h02}, '{4'hF, 1'b0, 8'h11}};
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rx_pkt_done = 1'b0;
    logic tx_active_in = 1'b0, rx_active_in = 1'b0, module_drain_in = 1'b0, pause_ack, tx_clk_tick;
    logic flow_ctrl_on, rx_stall, module_on, rx_path_on, packet_pending_flag, packet_pending_irq;
    logic [3:0] reg_addr = 4'h0, rx_pkt_desc = 4'h0, ack_wait = 4'h5;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rdv, ctl = 32'h0;
    logic [15:0] last_quanta;
    mfcb_pkg::mfcb_pause_s pause_req;
    int frames, bad_count = 0, compares = 0;
    always #10 clk = ~clk;
    mfcb_top #(.DESC_W(4)) mfcb_top_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_clk_tick(tx_clk_tick),
        .tx_active_in(tx_active_in), .rx_active_in(rx_active_in), .module_drain_in(module_drain_in),
        .rx_pkt_done(rx_pkt_done), .rx_pkt_desc(rx_pkt_desc), .pause_req(pause_req), .pause_ack(pause_ack),
        .flow_ctrl_on(flow_ctrl_on), .rx_stall(rx_stall), .module_on(module_on), .rx_path_on(rx_path_on),
        .packet_pending_flag(packet_pending_flag), .packet_pending_irq(packet_pending_irq));
    mfcb_mac_model #(.TICK_DIV(2)) mfcb_mac_model_i (.clk(clk), .rst_n(rst_n), .pause_req(pause_req),
        .ack_wait(ack_wait), .pause_ack(pause_ack), .tx_clk_tick(tx_clk_tick), .frames(frames),
        .last_quanta(last_quanta));
    // -------------------------------------------------------------------------
    // bus and check tasks
    // -------------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rdv = reg_rdata;
    endtask
    // packet done and decrement strobe land in the same cycle
    task automatic op(input logic [3:0] n, input logic dec);
        @(posedge clk);
        rx_pkt_done <= (n != 4'h0);
        rx_pkt_desc <= n;
        reg_addr <= mfcb_pkg::ADDR_CONTROL_ONE;
        reg_wdata <= ctl | 32'h1;
        reg_wr <= dec;
        @(posedge clk);
        rx_pkt_done <= 1'b0;
        reg_wr <= 1'b0;
    endtask
    task automatic cnt(input logic [7:0] e);
        rd(mfcb_pkg::ADDR_STATUS);
        chk("count", {24'h0, e}, {24'h0, rdv[23:16]});
    endtask
    task automatic wait_frames(input int n);
        for (int k = 0; k < 400 && frames < n; k++) @(posedge clk);
        chk("frames", n, frames);
    endtask
    task automatic tally_and_finish;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
    // -------------------------------------------------------------------------
    // tests
    // -------------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(mfcb_pkg::ADDR_STATUS); chk("status", 32'h0, rdv);
        rd(4'hF); chk("unmapped", 32'h0, rdv);
        foreach (rows[i]) begin
            op(rows[i].desc, rows[i].dec);
            cnt(rows[i].cnt);
        end
        $display("test count rows done");
        chk("pending", 1, packet_pending_flag);
        chk("irq off", 0, packet_pending_irq);
        wr(mfcb_pkg::ADDR_IRQ_ENABLES, 32'h40);
        repeat (2) @(posedge clk);
        #1;
        chk("irq on", 1, packet_pending_irq);
        wr(mfcb_pkg::ADDR_WATERMARKS, 32'h00FF_0002);
        ctl = 32'h80;
        wr(mfcb_pkg::ADDR_CONTROL_ONE, ctl);
        rd(mfcb_pkg::ADDR_CONTROL_ONE); chk("control", ctl, rdv);
        repeat (16) op(4'hF, 1'b0);
        cnt(8'hFF);
        chk("flow on", 1, flow_ctrl_on);
        chk("stall", 1, rx_stall);
        op(4'h0, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        chk("stall off", 0, rx_stall);
        op(4'h2, 1'b0);
        ctl = 32'h0;
        wr(mfcb_pkg::ADDR_CONTROL_ONE, ctl);
        op(4'h2, 1'b0);
        cnt(8'hFF);
        chk("no stall", 0, rx_stall);
        ctl = 32'h80;
        wr(mfcb_pkg::ADDR_CONTROL_ONE, ctl);
        repeat (253) op(4'h0, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        chk("flow off", 0, flow_ctrl_on);
        $display("test flow control done");
        ctl = 32'h8100;
        wr(mfcb_pkg::ADDR_CONTROL_ONE, ctl);
        tx_active_in <= 1'b1;
        rx_active_in <= 1'b1;
        repeat (3) @(posedge clk);
        rd(mfcb_pkg::ADDR_STATUS); chk("busy on", 32'h0002_00E0, rdv);
        chk("paths on", 32'h3, {30'h0, module_on, rx_path_on});
        ctl = 32'h0;
        wr(mfcb_pkg::ADDR_CONTROL_ONE, ctl);
        repeat (8) @(posedge clk);
        rd(mfcb_pkg::ADDR_STATUS); chk("busy off", 32'h0002_0000, rdv);
        chk("paths off", 32'h0, {30'h0, module_on, rx_path_on});
        @(posedge clk);
        module_drain_in <= 1'b1;
        repeat (2) @(posedge clk);
        rd(mfcb_pkg::ADDR_STATUS); chk("draining", 32'h0002_0080, rdv);
        @(posedge clk);
        module_drain_in <= 1'b0;
        wr(mfcb_pkg::ADDR_RX_DESC_ST, 32'h0000_1234);
        cnt(8'h00);
        op(4'h0, 1'b1);
        cnt(8'h00);
        chk("pending clear", 0, packet_pending_flag);
        $display("test status done");
        wr(mfcb_pkg::ADDR_PAUSE_TIMER, 32'h1);
        ctl = 32'h10;
        wr(mfcb_pkg::ADDR_CONTROL_ONE, ctl);
        wait_frames(1);
        chk("quanta", 32'h1, {16'h0, last_quanta});
        repeat (100) @(posedge clk);
        chk("early resend", 1, frames);
        wait_frames(2);
        ack_wait <= 4'h0;
        ctl = 32'h0;
        wr(mfcb_pkg::ADDR_CONTROL_ONE, ctl);
        wait_frames(3);
        chk("zero quanta", 32'h0, {16'h0, last_quanta});
        $display("test pause done");
        tally_and_finish();
    end
endmodule
